// >>> rtl/pbc4_map.svh
/*
  Constants of the four-bit presettable binary counter: width, reset
  value, count step and terminal state.
  Assumes nothing; definitions only, safe to include more than once.
*/
`ifndef PBC4_MAP_SVH
`define PBC4_MAP_SVH

`define PBC4_WIDTH       4
`define PBC4_RESET_VALUE 4'h0
`define PBC4_STEP        4'h1
`define PBC4_ALL_ONES    4'hf

`endif

// >>> rtl/pbc4_pkg.sv
/*
  Types shared by the counter top and its mode decoder.
  Assumes pbc4_map.svh is reachable on the include path.
*/
`include "pbc4_map.svh"

package pbc4_pkg;

  typedef logic [`PBC4_WIDTH-1:0] pbc4_count_t;

  // Operation picked for the next clock edge
  typedef enum logic [1:0] {
    PBC4_MODE_CLEAR,
    PBC4_MODE_LOAD,
    PBC4_MODE_COUNT,
    PBC4_MODE_HOLD
  } pbc4_mode_t;

endpackage

// >>> rtl/pbc4_mode_decode.sv
/*
  Priority decoder that picks the counter's operation for the next edge.
  Assumes the caller has already folded the clear variant into
  sync_clear_act; all inputs are synchronous to the counter clock.
*/
`timescale 1ns/1ps

module pbc4_mode_decode (
  input  wire logic              sync_clear_act,
  input  wire logic              load_select_n,
  input  wire logic              parallel_count_gate,
  input  wire logic              trickle_count_gate,
  output pbc4_pkg::pbc4_mode_t   mode
);
  import pbc4_pkg::*;

  always_comb begin
    if (sync_clear_act) begin
      mode = PBC4_MODE_CLEAR;
    end else if (!load_select_n) begin
      mode = PBC4_MODE_LOAD;
    end else if (parallel_count_gate && trickle_count_gate) begin
      mode = PBC4_MODE_COUNT;
    end else begin
      mode = PBC4_MODE_HOLD;
    end
  end

endmodule

// >>> rtl/pbc4_counter.sv
/*
  Four-bit synchronous presettable binary up-counter with clear, load,
  count and hold, two count gates and a terminal-carry output.
  Assumes all control and data inputs are synchronous to mclk, except
  async_clear_n in the asynchronous clear build, which must be released
  clear of a clock edge by the surrounding logic.
*/
`timescale 1ns/1ps


module pbc4_counter #(
  parameter bit ASYNC_CLEAR = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  async_clear_n,
  input  wire logic                  sync_clear_n,
  input  wire logic                  load_select_n,
  input  wire logic                  parallel_count_gate,
  input  wire logic                  trickle_count_gate,
  input  wire pbc4_pkg::pbc4_count_t preset_inputs,
  output pbc4_pkg::pbc4_count_t      count_outputs,
  output logic                       terminal_carry_out
);
  import pbc4_pkg::*;

  pbc4_mode_t  mode;
  pbc4_count_t cnt_r;
  pbc4_count_t cnt_nxt;
  logic        sync_clear_act;
  logic        async_clear_act;

  // Only one clear input is live, chosen by the build variant
  assign sync_clear_act  = !ASYNC_CLEAR && !sync_clear_n;
  assign async_clear_act = ASYNC_CLEAR && !async_clear_n;

  pbc4_mode_decode u_decode (
    .sync_clear_act      (sync_clear_act),
    .load_select_n       (load_select_n),
    .parallel_count_gate (parallel_count_gate),
    .trickle_count_gate  (trickle_count_gate),
    .mode                (mode)
  );

  always_comb begin
    case (mode)
      PBC4_MODE_CLEAR: begin
        cnt_nxt = `PBC4_RESET_VALUE;
      end
      PBC4_MODE_LOAD: begin
        cnt_nxt = preset_inputs;
      end
      PBC4_MODE_COUNT: begin
        // Four-bit sum drops the carry, so all ones wraps to zero
        cnt_nxt = pbc4_count_t'(cnt_r + `PBC4_STEP);
      end
      PBC4_MODE_HOLD: begin
        cnt_nxt = cnt_r;
      end
      default: begin
        cnt_nxt = cnt_r;
      end
    endcase
    if (rst) begin
      cnt_nxt = `PBC4_RESET_VALUE;
    end
  end

  generate
    if (ASYNC_CLEAR) begin : g_async_clear
      always_ff @(posedge mclk or negedge async_clear_n) begin
        if (!async_clear_n) begin
          cnt_r <= `PBC4_RESET_VALUE;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end else begin : g_sync_clear
      always_ff @(posedge mclk) begin
        cnt_r <= cnt_nxt;
      end
    end
  endgenerate

  assign count_outputs = cnt_r;

  // Combinational from the trickle gate; may glitch while decoding
  assign terminal_carry_out = trickle_count_gate
                              && (cnt_r == `PBC4_ALL_ONES);

  // Checks

  a_edge_cause: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable(count_outputs) |->
      ($past(mode) != PBC4_MODE_HOLD) || $past(rst)
      || $past(async_clear_act) || async_clear_act
  ) else $error("count changed without a clocked cause");

  a_load_copy: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (!load_select_n && !sync_clear_act) |=>
      (count_outputs == $past(preset_inputs))
  ) else $error("load did not copy preset inputs");

  a_async_zero: assert property (
    @(posedge mclk) disable iff (rst)
    async_clear_act |->
      (count_outputs == `PBC4_RESET_VALUE) && !terminal_carry_out
  ) else $error("asynchronous clear left count or carry high");

  a_sync_zero: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    sync_clear_act |=>
      (count_outputs == `PBC4_RESET_VALUE) ##0 !terminal_carry_out
  ) else $error("synchronous clear did not zero the count");

  a_clear_over_load: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (sync_clear_act && !load_select_n
     && (preset_inputs != `PBC4_RESET_VALUE)) |=>
      (count_outputs == `PBC4_RESET_VALUE)
  ) else $error("load won over synchronous clear");

  a_load_over_count: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (!sync_clear_act && !load_select_n
     && parallel_count_gate && trickle_count_gate) |=>
      (count_outputs == $past(preset_inputs))
  ) else $error("count won over load");

  a_count_step: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (!sync_clear_act && load_select_n
     && parallel_count_gate && trickle_count_gate) |=>
      (count_outputs == pbc4_count_t'($past(count_outputs) + `PBC4_STEP))
  ) else $error("counter did not advance by one");

  a_hold_value: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (!sync_clear_act && load_select_n
     && !(parallel_count_gate && trickle_count_gate))
    ##1 (!sync_clear_act && load_select_n
     && !(parallel_count_gate && trickle_count_gate)) |=>
      $stable(count_outputs) && (count_outputs == $past(count_outputs, 2))
  ) else $error("counter moved while held");

  a_carry_full: assert property (
    @(posedge mclk) disable iff (rst)
    terminal_carry_out |->
      (count_outputs == `PBC4_ALL_ONES) && trickle_count_gate
  ) else $error("carry high away from all ones");

  a_carry_set: assert property (
    @(posedge mclk) disable iff (rst)
    (trickle_count_gate && (count_outputs == `PBC4_ALL_ONES))
      |-> terminal_carry_out
  ) else $error("carry low at all ones with trickle high");

  a_carry_gate: assert property (
    @(posedge mclk) disable iff (rst)
    (count_outputs == `PBC4_ALL_ONES) && $fell(trickle_count_gate)
      |-> !terminal_carry_out
  ) else $error("carry did not drop with the trickle gate");

  a_wrap_zero: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (terminal_carry_out && parallel_count_gate
     && load_select_n && !sync_clear_act) |=>
      (count_outputs == `PBC4_RESET_VALUE) && !terminal_carry_out
  ) else $error("all ones did not wrap to zero");

  a_reset_zero: assert property (
    @(posedge mclk)
    rst |=> (count_outputs == `PBC4_RESET_VALUE)
  ) else $error("reset did not zero the count");

  a_gate_hold: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (!sync_clear_act && load_select_n && !parallel_count_gate) |=>
      $stable(count_outputs)
  ) else $error("counter moved with the parallel gate low");

  a_trickle_hold: assert property (
    @(posedge mclk) disable iff (rst || async_clear_act)
    (!sync_clear_act && load_select_n && !trickle_count_gate) |=>
      $stable(count_outputs)
  ) else $error("counter moved with the trickle gate low");

  c_wrap: cover property (
    @(posedge mclk) disable iff (rst)
    (count_outputs == `PBC4_ALL_ONES) && (mode == PBC4_MODE_COUNT)
    ##1 (count_outputs == `PBC4_RESET_VALUE)
  );

  c_load: cover property (
    @(posedge mclk) disable iff (rst)
    (mode == PBC4_MODE_LOAD) && (preset_inputs == `PBC4_ALL_ONES)
  );

  c_sync_clear: cover property (
    @(posedge mclk) disable iff (rst)
    sync_clear_act && (count_outputs != `PBC4_RESET_VALUE)
  );

  c_carry_gated: cover property (
    @(posedge mclk) disable iff (rst)
    (count_outputs == `PBC4_ALL_ONES) && !trickle_count_gate
  );

  c_async_clear: cover property (
    @(posedge mclk)
    async_clear_act && !load_select_n
  );

endmodule

// >>> verification/pbc4_cascade_model.sv
/*
  Upper cascaded stage that counts on the lower stage's carry.
  Assumes it shares mclk and rst with the lower stage.
*/
`timescale 1ns/1ps

module pbc4_cascade_model (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             carry_in,
  input  wire logic             gate_in,
  output pbc4_pkg::pbc4_count_t upper_count
);
  import pbc4_pkg::*;
  // Carry serves only as a count gate, never as a clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      upper_count <= 4'h0;
    end else if (carry_in && gate_in) begin
      upper_count <= upper_count + 4'h1;
    end
  end
endmodule

// >>> verification/pbc4_counter_bench.sv
/*
  Bench: both clear builds share all inputs, upper stage on the carry.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps

module pbc4_counter_bench;
  import pbc4_pkg::*;
  logic        mclk, rst, async_clear_n, sync_clear_n, load_select_n;
  logic        parallel_count_gate, trickle_count_gate, carry_s, carry_a;
  pbc4_count_t preset_inputs, cnt_s, cnt_a, upper, exp_c;
  int          mismatches, n_compared, cycles;

  pbc4_counter #(.ASYNC_CLEAR(1'b0)) u_pbc4_counter (.mclk, .rst,
    .async_clear_n, .sync_clear_n, .load_select_n, .parallel_count_gate,
    .trickle_count_gate, .preset_inputs, .count_outputs(cnt_s),
    .terminal_carry_out(carry_s));
  pbc4_counter #(.ASYNC_CLEAR(1'b1)) u_pbc4_counter_async (.mclk, .rst,
    .async_clear_n, .sync_clear_n, .load_select_n, .parallel_count_gate,
    .trickle_count_gate, .preset_inputs, .count_outputs(cnt_a),
    .terminal_carry_out(carry_a));
  pbc4_cascade_model u_pbc4_cascade_model (.mclk, .rst, .carry_in(carry_s),
    .gate_in(parallel_count_gate), .upper_count(upper));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 400) begin
      mismatches++;
      close_out;
    end
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input pbc4_count_t g, input pbc4_count_t e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Sets controls at the falling edge, lets outputs settle
  task automatic drive(input logic l, p, t, input pbc4_count_t d);
    @(negedge mclk);
    load_select_n = l;
    parallel_count_gate = p;
    trickle_count_gate = t;
    preset_inputs = d;
    #1;
  endtask

  task automatic t_load;
    drive(1'b0, 1'b0, 1'b0, 4'ha);
    drive(1'b0, 1'b1, 1'b1, 4'h5);
    chk(cnt_s, 4'ha);
    drive(1'b1, 1'b0, 1'b0, 4'h0);
    chk(cnt_s, 4'h5);
  endtask

  task automatic t_count;
    exp_c = upper;
    drive(1'b0, 1'b0, 1'b0, 4'he);
    drive(1'b1, 1'b1, 1'b1, 4'h0);
    chk(cnt_s, 4'he);
    chk({3'h0, carry_s}, 4'h0);
    drive(1'b1, 1'b1, 1'b1, 4'h0);
    chk(cnt_s, 4'hf);
    chk({3'h0, carry_s}, 4'h1);
    drive(1'b1, 1'b0, 1'b0, 4'h0);
    chk(cnt_s, 4'h0);
    chk({3'h0, carry_s}, 4'h0);
    chk(upper, exp_c + 4'h1);
  endtask

  task automatic t_hold;
    drive(1'b0, 1'b0, 1'b0, 4'hf);
    drive(1'b1, 1'b0, 1'b1, 4'h0);
    chk({3'h0, carry_s}, 4'h1);
    drive(1'b1, 1'b1, 1'b0, 4'h0);
    chk(cnt_s, 4'hf);
    chk({3'h0, carry_s}, 4'h0);
    drive(1'b1, 1'b1, 1'b1, 4'h0);
    chk(cnt_s, 4'hf);
    chk({3'h0, carry_s}, 4'h1);
  endtask

  task automatic t_sync;
    drive(1'b0, 1'b1, 1'b1, 4'h7);
    sync_clear_n = 1'b0;
    drive(1'b1, 1'b0, 1'b0, 4'h0);
    sync_clear_n = 1'b1;
    chk(cnt_s, 4'h0);
    chk(cnt_a, 4'h7);
  endtask

  // Outside decode of state 5 into the clear shortens the cycle
  task automatic t_short;
    drive(1'b0, 1'b0, 1'b0, 4'h0);
    exp_c = 4'h0;
    repeat (8) begin
      drive(1'b1, 1'b1, 1'b1, 4'h0);
      chk(cnt_s, exp_c);
      sync_clear_n = (cnt_s == 4'h5) ? 1'b0 : 1'b1;
      exp_c = (exp_c == 4'h5) ? 4'h0 : exp_c + 4'h1;
    end
    sync_clear_n = 1'b1;
  endtask

  task automatic t_async;
    drive(1'b0, 1'b0, 1'b1, 4'hf);
    drive(1'b0, 1'b1, 1'b1, 4'h3);
    chk({3'h0, carry_a}, 4'h1);
    async_clear_n = 1'b0;
    #1;
    chk(cnt_a, 4'h0);
    chk({3'h0, carry_a}, 4'h0);
    chk(cnt_s, 4'hf);
    drive(1'b1, 1'b0, 1'b1, 4'h0);
    chk(cnt_a, 4'h0);
    chk(cnt_s, 4'h3);
    async_clear_n = 1'b1;
  endtask

  initial begin
    rst = 1'b1;
    async_clear_n = 1'b1;
    sync_clear_n = 1'b1;
    load_select_n = 1'b1;
    parallel_count_gate = 1'b0;
    trickle_count_gate = 1'b0;
    preset_inputs = 4'h0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    chk(cnt_s, 4'h0);
    t_load;
    t_count;
    t_hold;
    t_sync;
    t_short;
    t_async;
    close_out;
  end
endmodule
